// File: rtl/sdp_consts.vh
// Constants for the SRAM data-port and burst-order block
// Summary of operation
// RULE1: Read data is the captured address's contents
// RULE2: Output enable low drives data and parity
// RULE3: Output enable high releases data and parity
// RULE4: Write data phase forces outputs off
// RULE5: First cycle after deselect forces outputs off
// RULE6: Deselected device keeps outputs off
// RULE7: Parity lines behave exactly like data lines
// RULE8: Each parity bit follows its lane select
// RULE9: Strap low gives linear burst order
// RULE10: Strap high or open gives interleaved order
// RULE11: System keeps burst strap static while operating
// RULE12: Controller drives byte write gate low
// RULE13: Sleep request held low for normal operation
// RULE14: Store byte and parity only when selected
`ifndef SDP_CONSTS_VH
`define SDP_CONSTS_VH
`define SDP_LANES       4
`define SDP_LANE_BITS   8
`define SDP_ADDR_BITS   21
`define SDP_BURST_LIN   1'b0
`define SDP_BURST_INT   1'b1
`define SDP_RD_RST      36'h0_0000_0000
`endif

// File: rtl/sdp_data_port.v
// Data/parity port, tri-state control and burst order of a flow-through SRAM
`timescale 1ns/10ps
`include "sdp_consts.vh"
module sdp_data_port #(
  parameter LANES = `SDP_LANES,
  parameter LBITS = `SDP_LANE_BITS,
  parameter ABITS = `SDP_ADDR_BITS
) (
  // Clock and reset
  input  wire                     SYS_CLK_I,
  input  wire                     RESET_N_I,
  // Sequencer status from the device core
  input  wire                     DESELECTED_I,
  input  wire                     WRITE_PHASE_I,
  input  wire                     READ_PHASE_I,
  input  wire [ABITS-1:0]         CAPTURED_ADDR_I,
  input  wire                     BURST_START_I,
  input  wire                     BURST_ADVANCE_I,
  // Pins
  input  wire                     OUT_ENABLE_N_I,
  input  wire [LANES-1:0]         LANE_WRITE_SELECT_N_I,
  input  wire                     BURST_ORDER_I,
  input  wire [LANES*LBITS-1:0]   DATA_I,
  input  wire [LANES-1:0]         PARITY_LINES_I,
  output wire [LANES*LBITS-1:0]   DATA_O,
  output wire [LANES-1:0]         PARITY_LINES_O,
  output wire [LANES*LBITS-1:0]   DATA_OE_O,
  output wire [LANES-1:0]         PARITY_LINES_OE_O,
  // Memory array side
  output reg  [ABITS-1:0]         BURST_ADDR_O,
  output reg  [LANES-1:0]         LANE_STORE_O,
  output reg  [LANES*LBITS-1:0]   STORE_DATA_O,
  output reg  [LANES-1:0]         STORE_PARITY_O,
  input  wire [LANES*LBITS-1:0]   ARRAY_DATA_I,
  input  wire [LANES-1:0]         ARRAY_PARITY_I
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg  [1:0]       oe_n_sync_q;
  reg  [1:0]       order_sync_q;
  reg              desel_d1_q;
  reg  [1:0]       burst_cnt_q;
  reg  [ABITS-1:0] base_addr_q;
  reg  [LANES*LBITS-1:0] rd_data_q;
  reg  [LANES-1:0]       rd_par_q;
  wire             drive_en;
  wire [1:0]       burst_step;
  wire [1:0]       burst_lo;

  // Reset value 1 on both: outputs off, interleaved order as with the pull-up
  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      oe_n_sync_q  <= 2'h3;
      order_sync_q <= 2'h3;
      desel_d1_q   <= 1'b1;
    end else begin
      oe_n_sync_q  <= {oe_n_sync_q[0], OUT_ENABLE_N_I};
      order_sync_q <= {order_sync_q[0], BURST_ORDER_I};
      desel_d1_q   <= DESELECTED_I;
    end
  end

  // ----------------------------------------------------------------
  // Output drive decision
  // ----------------------------------------------------------------
  // One shared enable keeps data and parity lanes in lock-step
  assign drive_en = !oe_n_sync_q[1]     // RULE2 RULE3
                  && !WRITE_PHASE_I     // RULE4
                  && !desel_d1_q        // RULE5
                  && !DESELECTED_I;     // RULE6
  assign DATA_O            = rd_data_q;
  assign PARITY_LINES_O    = rd_par_q;                  // RULE7
  assign DATA_OE_O         = {(LANES*LBITS){drive_en}};
  assign PARITY_LINES_OE_O = {LANES{drive_en}};         // RULE7

  // ----------------------------------------------------------------
  // Burst address generation
  // ----------------------------------------------------------------
  // Strap is only sampled, never latched: it is expected to stay static
  // The step is the count after this advance, so the first advance moves on
  assign burst_step = burst_cnt_q + 2'h1;
  assign burst_lo = (order_sync_q[1] == `SDP_BURST_LIN) ?
                    (base_addr_q[1:0] + burst_step) :      // RULE9
                    (base_addr_q[1:0] ^ burst_step);       // RULE10 RULE11

  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      base_addr_q  <= {ABITS{1'b0}};
      burst_cnt_q  <= 2'h0;
      BURST_ADDR_O <= {ABITS{1'b0}};
    end else begin
      if (BURST_START_I) begin
        base_addr_q  <= CAPTURED_ADDR_I;
        burst_cnt_q  <= 2'h0;
        BURST_ADDR_O <= CAPTURED_ADDR_I;
      end else if (BURST_ADVANCE_I) begin
        burst_cnt_q  <= burst_step;
        BURST_ADDR_O <= {base_addr_q[ABITS-1:2], burst_lo};
      end
    end
  end

  // ----------------------------------------------------------------
  // Read capture and per-lane write store
  // ----------------------------------------------------------------
  always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      rd_data_q <= {(LANES*LBITS){1'b0}};
      rd_par_q  <= {LANES{1'b0}};
    end else if (READ_PHASE_I) begin
      rd_data_q <= ARRAY_DATA_I;      // RULE1
      rd_par_q  <= ARRAY_PARITY_I;    // RULE1 RULE7
    end
  end

  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      always @(posedge SYS_CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
          LANE_STORE_O[g]                 <= 1'b0;
          STORE_DATA_O[g*LBITS +: LBITS]  <= {LBITS{1'b0}};
          STORE_PARITY_O[g]               <= 1'b0;
        end else begin
          LANE_STORE_O[g] <= WRITE_PHASE_I && !LANE_WRITE_SELECT_N_I[g];  // RULE8 RULE14
          STORE_DATA_O[g*LBITS +: LBITS] <= DATA_I[g*LBITS +: LBITS];
          STORE_PARITY_O[g] <= PARITY_LINES_I[g];                        // RULE7 RULE8
        end
      end
    end
  endgenerate

endmodule // sdp_data_port

// File: tb/sdp_chk.sv
// Checker for the data-port tri-state, store and burst-load behaviour
`timescale 1ns/10ps
module sdp_chk (
  input wire SYS_CLK_I, RESET_N_I, DESELECTED_I, WRITE_PHASE_I, READ_PHASE_I, BURST_START_I,
  input wire OUT_ENABLE_N_I, BURST_ADVANCE_I, BURST_ORDER_I,
  input wire [20:0] CAPTURED_ADDR_I, BURST_ADDR_O,
  input wire [3:0] LANE_WRITE_SELECT_N_I, PARITY_LINES_I, PARITY_LINES_O, PARITY_LINES_OE_O,
  input wire [3:0] LANE_STORE_O, STORE_PARITY_O, ARRAY_PARITY_I,
  input wire [31:0] DATA_O, DATA_OE_O, ARRAY_DATA_I);
  default clocking @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESET_N_I);
  // Three samples cover the two-stage enable synchroniser
  sequence s_drive; (!OUT_ENABLE_N_I && !DESELECTED_I && !WRITE_PHASE_I)[*3]; endsequence
  sequence s_off; OUT_ENABLE_N_I[*3]; endsequence
  sequence s_load_adv; BURST_START_I ##1 BURST_ADVANCE_I; endsequence
  a_read_data: assert property (READ_PHASE_I |=>
    {PARITY_LINES_O, DATA_O} == $past({ARRAY_PARITY_I, ARRAY_DATA_I})) else $error("read data");
  a_oe_drive: assert property (s_drive |-> &{PARITY_LINES_OE_O, DATA_OE_O}) else $error("no drive");
  a_oe_off: assert property (s_off |-> !(|{PARITY_LINES_OE_O, DATA_OE_O})) else $error("oe off");
  a_write_off: assert property (WRITE_PHASE_I |-> !(|DATA_OE_O)) else $error("drive in write");
  a_desel_exit: assert property ($fell(DESELECTED_I) |-> !(|DATA_OE_O)) else $error("exit drive");
  a_desel_off: assert property (DESELECTED_I |-> !(|DATA_OE_O)) else $error("drive deselected");
  a_parity_same: assert property (PARITY_LINES_OE_O == {4{DATA_OE_O[0]}}
    && DATA_OE_O == {32{DATA_OE_O[0]}}) else $error("parity enable differs");
  a_lane_store: assert property (WRITE_PHASE_I |=> LANE_STORE_O == ~$past(LANE_WRITE_SELECT_N_I)
    && (STORE_PARITY_O & LANE_STORE_O) == ($past(PARITY_LINES_I) & LANE_STORE_O)) else $error("store");
  a_no_store: assert property (!WRITE_PHASE_I |=> LANE_STORE_O == 4'h0) else $error("stray store");
  a_burst_load: assert property (BURST_START_I |=> BURST_ADDR_O == $past(CAPTURED_ADDR_I))
    else $error("burst load");
  a_burst_step: assert property (s_load_adv |=> BURST_ADDR_O[1:0] == (BURST_ORDER_I ?
    ($past(BURST_ADDR_O[1:0]) ^ 2'h1) : ($past(BURST_ADDR_O[1:0]) + 2'h1))) else $error("burst step");
endmodule // sdp_chk
bind sdp_data_port sdp_chk i_chk (.*);

// File: tb/sdp_mem_model.sv
// Array model: per-lane stores, reads follow the burst address
`timescale 1ns/10ps
module sdp_mem_model (
  input wire clk_i,
  input wire [1:0] addr_i,
  input wire [3:0] store_i, par_i,
  input wire [31:0] data_i,
  output wire [31:0] data_o,
  output wire [3:0] par_o);
  logic [35:0] mem_q [4];
  always @(posedge clk_i) begin
    for (int g = 0; g < 4; g++) if (store_i[g]) begin
      mem_q[addr_i][8*g+:8] <= data_i[8*g+:8];
      mem_q[addr_i][32+g] <= par_i[g];
    end
  end
  assign {par_o, data_o} = mem_q[addr_i];
endmodule // sdp_mem_model

// File: tb/sdp_data_port_bench.sv
// Bench for the data-port block
`timescale 1ns/10ps
module sdp_data_port_bench;
  logic clk = 0, rst_n = 0, desel = 1, wr = 0, rd = 0, st = 0, adv = 0, oe_n = 1, mode = 0;
  logic [20:0] ca = 21'h0_0000;
  logic [3:0] sel_n = 4'hF, pi = 4'h0;
  logic [31:0] di = 32'h0000_0000;
  wire [31:0] dout, doe, ad, sd;
  wire [3:0] pout, poe, ls, ap, sp;
  wire [20:0] ba;
  int error_cnt = 0, total_checks = 0;
  always #2.5 clk = ~clk;
  sdp_data_port i_dut (.SYS_CLK_I(clk), .RESET_N_I(rst_n), .DESELECTED_I(desel), .WRITE_PHASE_I(wr),
    .READ_PHASE_I(rd), .CAPTURED_ADDR_I(ca), .BURST_START_I(st), .BURST_ADVANCE_I(adv),
    .OUT_ENABLE_N_I(oe_n), .LANE_WRITE_SELECT_N_I(sel_n), .BURST_ORDER_I(mode), .DATA_I(di),
    .PARITY_LINES_I(pi), .DATA_O(dout), .PARITY_LINES_O(pout), .DATA_OE_O(doe),
    .PARITY_LINES_OE_O(poe), .BURST_ADDR_O(ba), .LANE_STORE_O(ls), .STORE_DATA_O(sd),
    .STORE_PARITY_O(sp), .ARRAY_DATA_I(ad), .ARRAY_PARITY_I(ap));
  sdp_mem_model i_mem (.clk_i(clk), .addr_i(ba[1:0]), .store_i(ls),
    .par_i(sp), .data_i(sd), .data_o(ad), .par_o(ap));
  task cyc(int n = 1); repeat (n) @(posedge clk); #1; endtask
  task chk(logic [35:0] g, logic [35:0] e);
    total_checks++;
    if (g !== e) begin error_cnt++; $display("BAD %0t got %h exp %h", $time, g, e); end
  endtask
  task t_oe;
    oe_n = 0; cyc(3); chk({poe, doe}, 36'h0_0000_0000);
    desel = 0; #1 chk({poe, doe}, 36'h0_0000_0000);
    cyc; chk({poe, doe}, 36'hF_FFFF_FFFF);
    desel = 1; cyc; chk({poe, doe}, 36'h0_0000_0000);
    desel = 0; wr = 1; cyc(2); chk({poe, doe}, 36'h0_0000_0000);
    wr = 0; oe_n = 1; cyc(3); chk({poe, doe}, 36'h0_0000_0000);
  endtask
  task t_wr_rd;
    ca = 21'h0_0002; st = 1; cyc; st = 0; wr = 1; sel_n = 4'h0; di = 32'h0123_4567; pi = 4'hF;
    cyc; sel_n = 4'h5; di = 32'h89AB_CDEF; pi = 4'h0; cyc; wr = 0; cyc; rd = 1; cyc; rd = 0;
    chk({pout, dout}, 36'h5_8923_CD67);
  endtask
  task t_burst(logic m);
    rst_n = 0; mode = m; cyc(2); rst_n = 1; cyc(3);
    ca = 21'h1_2345; st = 1; cyc; st = 0; adv = 1; chk(ba, ca);
    for (int i = 1; i < 4; i++) begin
      cyc; chk(ba, {ca[20:2], m ? ca[1:0] ^ 2'(i) : ca[1:0] + 2'(i)});
    end
    adv = 0;
  endtask
  task test_done;
    if (error_cnt == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    cyc(2); rst_n = 1; cyc(3);
    t_oe; t_wr_rd; t_burst(0); t_burst(1); test_done;
  end
endmodule // sdp_data_port_bench
